// ### rtl/pfta_top.sv
`timescale 1ns/1ps
module pfta_top #(
	parameter int unsigned MEM_AW = 14,
	parameter int unsigned PROG_CYCLES = pfta_pkg::PFTA_PROG_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [pfta_pkg::PFTA_WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic fetch_req_i,
	input wire logic [MEM_AW-1:0] fetch_addr_i,
	output logic [15:0] fetch_data_o,
	output logic fetch_valid_o,
	output logic fetch_stall_o
);

	logic [7:0] latch_q, latch_d;
	logic [7:0] ptr_low_q, ptr_low_d;
	logic [7:0] ptr_high_q, ptr_high_d;
	logic [7:0] ptr_upper_q, ptr_upper_d;
	logic [7:0] hold_q [0:pfta_pkg::PFTA_WRITE_BLOCK_BYTES-1];
	logic [7:0] hold_d [0:pfta_pkg::PFTA_WRITE_BLOCK_BYTES-1];
	logic [2:0] pend_cmd_q, pend_cmd_d;
	logic pend_q, pend_d;
	logic refused_q, refused_d;
	logic erase_q, erase_d;
	logic [23:0] op_ptr_q, op_ptr_d;
	logic [4:0] cnt_q, cnt_d;
	logic [11:0] timer_q, timer_d;
	pfta_pkg::pfta_state_t state_q, state_d;
	logic [31:0] dat_q, dat_d;
	logic ack_q, ack_d;
	logic [15:0] fdata_q, fdata_d;
	logic fvalid_q, fvalid_d;
	logic stall_q, stall_d;

	logic [MEM_AW-1:0] mem_addr;
	logic mem_we;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;

	logic [23:0] tbl_ptr;
	logic [11:0] idx;
	logic bus_req, bus_wr;
	logic [4:0] last_word;

	// byte address from the three pointer bytes
	assign tbl_ptr = {ptr_upper_q, ptr_high_q, ptr_low_q}; // [R14]
	assign idx = wb_adr_i[pfta_pkg::PFTA_WB_AW-1:2];
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
	assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
	assign last_word = erase_q ? 5'(pfta_pkg::PFTA_ERASE_BLOCK_WORDS - 1)
		: 5'(pfta_pkg::PFTA_WRITE_BLOCK_WORDS - 1);

	pfta_mem #(
		.AW(MEM_AW),
		.DW(pfta_pkg::PFTA_WORD_W)
	) u_mem (
		.clk_i(clk_i),
		.ce_i(ce_i),
		.addr_i(mem_addr),
		.we_i(mem_we),
		.wdata_i(mem_wdata),
		.rdata_o(mem_rdata)
	);

	always_comb
	begin
		latch_d = latch_q;
		ptr_low_d = ptr_low_q;
		ptr_high_d = ptr_high_q;
		ptr_upper_d = ptr_upper_q;
		hold_d = hold_q;
		pend_cmd_d = pend_cmd_q;
		pend_d = pend_q;
		refused_d = refused_q;
		erase_d = erase_q;
		op_ptr_d = op_ptr_q;
		cnt_d = cnt_q;
		timer_d = timer_q;
		state_d = state_q;
		dat_d = 32'h0000_0000;
		ack_d = bus_req;
		fdata_d = fdata_q;
		fvalid_d = 1'b0;
		mem_addr = fetch_addr_i;
		mem_we = 1'b0;
		mem_wdata = pfta_pkg::PFTA_ERASED_WORD;

		// bus side: registers answer one cycle after the strobe
		if (bus_req && !wb_we_i)
		begin
			case (idx)
				pfta_pkg::PFTA_IDX_LATCH: dat_d = {24'h000000, latch_q};
				pfta_pkg::PFTA_IDX_PTR_LOW: dat_d = {24'h000000, ptr_low_q};
				pfta_pkg::PFTA_IDX_PTR_HIGH: dat_d = {24'h000000, ptr_high_q};
				pfta_pkg::PFTA_IDX_PTR_UPPER: dat_d = {24'h000000, ptr_upper_q};
				pfta_pkg::PFTA_IDX_CMD: dat_d = {29'h00000000, pend_cmd_q};
				pfta_pkg::PFTA_IDX_STATUS:
				begin
					dat_d[pfta_pkg::PFTA_STAT_BUSY] = stall_q;
					dat_d[pfta_pkg::PFTA_STAT_PEND] = pend_q;
					dat_d[pfta_pkg::PFTA_STAT_REFUSED] = refused_q;
				end
				default: dat_d = 32'h0000_0000;
			endcase
		end
		if (bus_wr)
		begin
			case (idx)
				pfta_pkg::PFTA_IDX_LATCH: latch_d = wb_dat_i[7:0];
				pfta_pkg::PFTA_IDX_PTR_LOW: ptr_low_d = wb_dat_i[7:0];
				pfta_pkg::PFTA_IDX_PTR_HIGH: ptr_high_d = wb_dat_i[7:0];
				pfta_pkg::PFTA_IDX_PTR_UPPER: ptr_upper_d = wb_dat_i[7:0];
				pfta_pkg::PFTA_IDX_CMD:
				begin
					// a second command before the first starts is dropped
					if (wb_dat_i[2:0] == pfta_pkg::PFTA_CMD_BULK_ERASE || pend_q)
					begin
						refused_d = 1'b1; // [R05]
					end
					else if (wb_dat_i[2:0] >= pfta_pkg::PFTA_CMD_TABLE_READ
						&& wb_dat_i[2:0] <= pfta_pkg::PFTA_CMD_ERASE)
					begin
						pend_d = 1'b1;
						pend_cmd_d = wb_dat_i[2:0];
					end
				end
				pfta_pkg::PFTA_IDX_STATUS:
				begin
					// write one to clear; refusals only come from command writes, so the two never meet
					if (wb_dat_i[pfta_pkg::PFTA_STAT_REFUSED])
					begin
						refused_d = 1'b0;
					end
				end
				default: ;
			endcase
		end

		case (state_q)
			pfta_pkg::PFTA_S_IDLE:
			begin
				// commands run between fetches, with no special mode [R01]
				if (pend_q)
				begin
					pend_d = 1'b0;
					pend_cmd_d = 3'h0;
					op_ptr_d = tbl_ptr;
					cnt_d = 5'h00;
					case (pend_cmd_q)
						pfta_pkg::PFTA_CMD_TABLE_READ:
						begin
							mem_addr = tbl_ptr[MEM_AW:1]; // [R09] [R13]
							state_d = pfta_pkg::PFTA_S_READ_TAKE;
						end
						pfta_pkg::PFTA_CMD_TABLE_WRITE:
						begin
							hold_d[tbl_ptr[2:0]] = latch_q; // [R10] [R12]
						end
						pfta_pkg::PFTA_CMD_PROGRAM:
						begin
							erase_d = 1'b0;
							state_d = pfta_pkg::PFTA_S_PROG;
						end
						pfta_pkg::PFTA_CMD_ERASE:
						begin
							erase_d = 1'b1;
							state_d = pfta_pkg::PFTA_S_PROG;
						end
						default: ;
					endcase
				end
				else if (fetch_req_i)
				begin
					mem_addr = fetch_addr_i;
					state_d = pfta_pkg::PFTA_S_FETCH_TAKE;
				end
			end
			pfta_pkg::PFTA_S_READ_TAKE:
			begin
				// one byte of the sixteen-bit word, odd address takes the high half
				latch_d = op_ptr_q[0] ? mem_rdata[15:8] : mem_rdata[7:0]; // [R02] [R09] [R10] [R11]
				state_d = pfta_pkg::PFTA_S_IDLE;
			end
			pfta_pkg::PFTA_S_FETCH_TAKE:
			begin
				fvalid_d = 1'b1;
				if (mem_rdata[15:8] == pfta_pkg::PFTA_UNDEF_OP_HI)
				begin
					fdata_d = pfta_pkg::PFTA_NOP_WORD; // [R08]
				end
				else
				begin
					fdata_d = mem_rdata;
				end
				state_d = pfta_pkg::PFTA_S_IDLE;
			end
			pfta_pkg::PFTA_S_PROG:
			begin
				mem_we = 1'b1;
				if (erase_q)
				begin
					mem_addr = {op_ptr_q[MEM_AW:6], cnt_q[4:0]}; // [R04]
					mem_wdata = pfta_pkg::PFTA_ERASED_WORD;
				end
				else
				begin
					mem_addr = {op_ptr_q[MEM_AW:3], cnt_q[1:0]}; // [R03]
					mem_wdata = {hold_q[{cnt_q[1:0], 1'b1}], hold_q[{cnt_q[1:0], 1'b0}]}; // [R03]
				end
				if (cnt_q == last_word)
				begin
					timer_d = 12'(PROG_CYCLES - 1);
					state_d = pfta_pkg::PFTA_S_TIMER;
				end
				else
				begin
					cnt_d = cnt_q + 5'h01;
				end
			end
			pfta_pkg::PFTA_S_TIMER:
			begin
				// only the timer ends the operation [R07]
				if (timer_q == 12'h000)
				begin
					state_d = pfta_pkg::PFTA_S_IDLE;
				end
				else
				begin
					timer_d = timer_q - 12'h001;
				end
			end
			default: state_d = pfta_pkg::PFTA_S_IDLE;
		endcase

		// no fetch is taken while the array is being altered [R06]
		stall_d = (state_d == pfta_pkg::PFTA_S_PROG) || (state_d == pfta_pkg::PFTA_S_TIMER);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			latch_q <= pfta_pkg::PFTA_LATCH_RST;
			ptr_low_q <= pfta_pkg::PFTA_PTR_RST;
			ptr_high_q <= pfta_pkg::PFTA_PTR_RST;
			ptr_upper_q <= pfta_pkg::PFTA_PTR_RST;
			for (int i = 0; i < pfta_pkg::PFTA_WRITE_BLOCK_BYTES; i++)
			begin
				hold_q[i] <= pfta_pkg::PFTA_HOLD_RST;
			end
			pend_cmd_q <= 3'h0;
			pend_q <= 1'b0;
			refused_q <= 1'b0;
			erase_q <= 1'b0;
			op_ptr_q <= 24'h000000;
			cnt_q <= 5'h00;
			timer_q <= 12'h000;
			state_q <= pfta_pkg::PFTA_S_IDLE;
			dat_q <= 32'h0000_0000;
			ack_q <= 1'b0;
			fdata_q <= pfta_pkg::PFTA_NOP_WORD;
			fvalid_q <= 1'b0;
			stall_q <= 1'b0;
		end
		else if (ce_i)
		begin
			latch_q <= latch_d;
			ptr_low_q <= ptr_low_d;
			ptr_high_q <= ptr_high_d;
			ptr_upper_q <= ptr_upper_d;
			hold_q <= hold_d;
			pend_cmd_q <= pend_cmd_d;
			pend_q <= pend_d;
			refused_q <= refused_d;
			erase_q <= erase_d;
			op_ptr_q <= op_ptr_d;
			cnt_q <= cnt_d;
			timer_q <= timer_d;
			state_q <= state_d;
			dat_q <= dat_d;
			ack_q <= ack_d;
			fdata_q <= fdata_d;
			fvalid_q <= fvalid_d;
			stall_q <= stall_d;
		end
	end

	assign wb_dat_o = dat_q;
	assign wb_ack_o = ack_q;
	assign fetch_data_o = fdata_q;
	assign fetch_valid_o = fvalid_q;
	assign fetch_stall_o = stall_q;

endmodule : pfta_top

// ### include/pfta_pkg.sv
// Behaviour
// [R01] flash read, write, erase during normal operation
// [R02] each table read returns one byte
// [R03] program commits whole eight-byte holding block
// [R04] erase clears one sixty-four byte block
// [R05] bulk erase from application code is refused
// [R06] fetches and accesses stall during program/erase; only fetches stall here, the bus still answers register accesses
// [R07] on-chip timer ends every program/erase
// [R08] undefined opcode fetched executes as no-operation
// [R09] sixteen-bit program memory, eight-bit data side
// [R10] all table transfers pass the byte latch
// [R11] table read copies addressed byte to latch
// [R12] table write fills holding registers only
// [R13] any byte address; code must stay word aligned
// [R14] pointer bytes concatenate upper-to-lower into address
package pfta_pkg;

	// register word indices; byte address is index times four
	localparam int unsigned PFTA_IDX_W = 12;
	localparam logic [11:0] PFTA_IDX_LATCH = 12'hff5;
	localparam logic [11:0] PFTA_IDX_PTR_LOW = 12'hff6;
	localparam logic [11:0] PFTA_IDX_PTR_HIGH = 12'hff7;
	localparam logic [11:0] PFTA_IDX_PTR_UPPER = 12'hff8;
	localparam logic [11:0] PFTA_IDX_CMD = 12'hf00;
	localparam logic [11:0] PFTA_IDX_STATUS = 12'hf01;
	localparam int unsigned PFTA_WB_AW = 14;

	// command register field, bits 2:0
	localparam int unsigned PFTA_CMD_W = 3;
	localparam logic [2:0] PFTA_CMD_TABLE_READ = 3'h1;
	localparam logic [2:0] PFTA_CMD_TABLE_WRITE = 3'h2;
	localparam logic [2:0] PFTA_CMD_PROGRAM = 3'h3;
	localparam logic [2:0] PFTA_CMD_ERASE = 3'h4;
	localparam logic [2:0] PFTA_CMD_BULK_ERASE = 3'h5;

	// status register bit positions
	localparam int unsigned PFTA_STAT_BUSY = 0;
	localparam int unsigned PFTA_STAT_PEND = 1;
	localparam int unsigned PFTA_STAT_REFUSED = 2;

	// reset and fill values
	localparam logic [7:0] PFTA_LATCH_RST = 8'h00;
	localparam logic [7:0] PFTA_PTR_RST = 8'h00;
	localparam logic [7:0] PFTA_HOLD_RST = 8'hff;
	localparam logic [15:0] PFTA_ERASED_WORD = 16'hffff;
	localparam logic [15:0] PFTA_NOP_WORD = 16'h0000;
	localparam logic [7:0] PFTA_UNDEF_OP_HI = 8'h01;

	// geometry
	localparam int unsigned PFTA_WORD_W = 16;
	localparam int unsigned PFTA_BYTE_W = 8;
	localparam int unsigned PFTA_PTR_W = 24;
	localparam int unsigned PFTA_WRITE_BLOCK_BYTES = 8;
	localparam int unsigned PFTA_ERASE_BLOCK_BYTES = 64;
	localparam int unsigned PFTA_WRITE_BLOCK_WORDS = PFTA_WRITE_BLOCK_BYTES / 2;
	localparam int unsigned PFTA_ERASE_BLOCK_WORDS = PFTA_ERASE_BLOCK_BYTES / 2;

	// programming timer
	localparam int unsigned PFTA_CLK_PERIOD_NS = 5;
	localparam int unsigned PFTA_PROG_TIME_NS = 2000;
	localparam int unsigned PFTA_PROG_CYCLES = (PFTA_PROG_TIME_NS + PFTA_CLK_PERIOD_NS - 1) / PFTA_CLK_PERIOD_NS;
	localparam int unsigned PFTA_TIMER_W = 12;

	typedef enum logic [2:0] {
		PFTA_S_IDLE,
		PFTA_S_READ_TAKE,
		PFTA_S_FETCH_TAKE,
		PFTA_S_PROG,
		PFTA_S_TIMER
	} pfta_state_t;

endpackage : pfta_pkg

// ### rtl/pfta_mem.sv
`timescale 1ns/1ps
module pfta_mem #(
	parameter int unsigned AW = 14,
	parameter int unsigned DW = 16
) (
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic we_i,
	input wire logic [DW-1:0] wdata_i,
	output logic [DW-1:0] rdata_o
);

	logic [DW-1:0] mem_q [0:(1<<AW)-1];
	logic [DW-1:0] rdata_q;

	// contents are not reset; software erases before trusting them
	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			if (we_i)
			begin
				mem_q[addr_i] <= wdata_i;
			end
			rdata_q <= mem_q[addr_i];
		end
	end

	assign rdata_o = rdata_q;

endmodule : pfta_mem

// ### verif/pfta_top_checker.sv
`timescale 1ns/1ps
module pfta_top_checker #(
	parameter int unsigned MEM_AW = 14,
	parameter int unsigned PROG_CYCLES = pfta_pkg::PFTA_PROG_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic fetch_req_i,
	input wire logic [15:0] fetch_data_o,
	input wire logic fetch_valid_o,
	input wire logic fetch_stall_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_ack_follows:
		assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
	a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack held");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
	a_dat_byte: assert property (wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
	a_valid_cause: assert property (fetch_valid_o |-> $past(fetch_req_i, 2)) else $error("fetch without request");
	a_valid_single: assert property (fetch_valid_o && ce_i |=> !fetch_valid_o) else $error("valid held");
	a_stall_blocks: assert property (fetch_stall_o |-> !fetch_valid_o) else $error("fetch served in stall");
	a_stall_ends: assert property ($rose(fetch_stall_o) |-> ##[1:1000] !fetch_stall_o) else $error("stall stuck");
	a_nop_fetch:
		assert property (fetch_valid_o |-> fetch_data_o[15:8] != pfta_pkg::PFTA_UNDEF_OP_HI) else $error("opcode passed");
	c_stall: cover property ($rose(fetch_stall_o));
	c_fetch: cover property (fetch_valid_o);
	c_write: cover property (wb_ack_o && wb_we_i);
endmodule : pfta_top_checker

bind pfta_top pfta_top_checker #(.MEM_AW(MEM_AW), .PROG_CYCLES(PROG_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .fetch_req_i(fetch_req_i), .fetch_data_o(fetch_data_o), .fetch_valid_o(fetch_valid_o),
	.fetch_stall_o(fetch_stall_o));

// ### verif/pfta_core_model.sv
`timescale 1ns/1ps
// core fetch side: holds its request through any stall
module pfta_core_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [13:0] addr_i,
	input wire logic valid_i,
	output logic req_o,
	output logic [13:0] addr_o
);
	logic req_q;
	logic req_d;
	logic [13:0] addr_q;
	logic [13:0] addr_d;
	always_comb
	begin
		req_d = req_q;
		addr_d = addr_q;
		if (start_i)
		begin
			req_d = 1'b1;
			addr_d = addr_i;
		end
		else if (valid_i && req_q)
		begin
			req_d = 1'b0;
			addr_d = ~addr_q;
		end
	end
	always_ff @(posedge clk_i)
	begin
		req_q <= rst_i ? 1'b0 : req_d;
		addr_q <= addr_d;
	end
	assign req_o = req_q;
	assign addr_o = addr_q;
endmodule : pfta_core_model

// ### verif/pfta_top_bench.sv
`timescale 1ns/1ps
module pfta_top_bench;
	localparam logic [11:0] LAT = pfta_pkg::PFTA_IDX_LATCH;
	localparam logic [11:0] PLO = pfta_pkg::PFTA_IDX_PTR_LOW;
	localparam logic [11:0] CMD = pfta_pkg::PFTA_IDX_CMD;
	localparam logic [11:0] STA = pfta_pkg::PFTA_IDX_STATUS;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [13:0] adr = 14'h0;
	logic [3:0] sel = 4'h1;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic start = 1'b0;
	logic [13:0] fa_in = 14'h0;
	logic freq;
	logic [13:0] fa;
	logic [15:0] fdata;
	logic fvalid;
	logic fstall;
	logic [31:0] s;
	int miscompares = 0;
	int cmp_count = 0;
	pfta_top #(.MEM_AW(14), .PROG_CYCLES(8)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .fetch_req_i(freq), .fetch_addr_i(fa), .fetch_data_o(fdata), .fetch_valid_o(fvalid),
		.fetch_stall_o(fstall));
	pfta_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .addr_i(fa_in), .valid_i(fvalid),
		.req_o(freq), .addr_o(fa));
	initial
		forever #2.5 clk_i = ~clk_i;
	task automatic summarize;
		if (miscompares == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		do @(posedge clk_i); while (ack !== 1'b1 && ++n < 100);
		s = rdat;
		if (ack !== 1'b1) miscompares++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic rdchk(input string name, input logic [11:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h0);
		chk(name, s, exp);
	endtask : rdchk
	task automatic wait_idle;
		int n;
		n = 0;
		do bus(1'b0, STA, 8'h0); while (s[1:0] !== 2'b00 && ++n < 200);
		if (s[1:0] !== 2'b00) miscompares++;
	endtask : wait_idle
	task automatic fetch(input logic [13:0] a, input logic [15:0] exp);
		int n;
		n = 0;
		fa_in <= a;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		do @(posedge clk_i); while (fvalid !== 1'b1 && ++n < 200);
		chk("fetch valid", {31'h0, fvalid}, 32'h1);
		chk("fetch", {16'h0, fdata}, {16'h0, exp});
		repeat (4) @(posedge clk_i);
	endtask : fetch
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdchk("latch", LAT, 32'h0);
		rdchk("ptr_upper", pfta_pkg::PFTA_IDX_PTR_UPPER, 32'h0);
		rdchk("status", STA, 32'h0);
		bus(1'b1, 12'h100, 8'h5a);
		rdchk("unmapped", 12'h100, 32'h0);
		bus(1'b1, pfta_pkg::PFTA_IDX_PTR_HIGH, 8'h01);
		bus(1'b1, PLO, 8'h40);
		bus(1'b1, CMD, 8'h04);
		repeat (10) @(posedge clk_i);
		chk("erase stall", fstall, 32'h1);
		fetch(14'h0a0, 16'hffff);
		fetch(14'h0bf, 16'hffff);
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b1, PLO, 8'h40 + 8'(i));
			bus(1'b1, LAT, i == 1 ? 8'h01 : 8'ha0 + 8'(i));
			bus(1'b1, CMD, 8'h02);
			wait_idle();
		end
		fetch(14'h0a1, 16'hffff);
		bus(1'b1, PLO, 8'h40);
		bus(1'b1, CMD, 8'h03);
		repeat (6) @(posedge clk_i);
		chk("program stall", fstall, 32'h1);
		wait_idle();
		fetch(14'h0a0, 16'h0000);
		fetch(14'h0a1, 16'ha3a2);
		fetch(14'h0a3, 16'ha7a6);
		fetch(14'h0a4, 16'hffff);
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b1, PLO, i == 0 ? 8'h45 : 8'h41);
			bus(1'b1, CMD, 8'h01);
			wait_idle();
			rdchk("table read", LAT, i == 0 ? 32'ha5 : 32'h01);
		end
		bus(1'b1, CMD, 8'h05);
		rdchk("refused", STA, 32'h4);
		bus(1'b1, STA, 8'h04);
		rdchk("cleared", STA, 32'h0);
		fetch(14'h0a1, 16'ha3a2);
		// a second command while one waits behind a running program is dropped
		bus(1'b1, PLO, 8'h44);
		bus(1'b1, CMD, 8'h03);
		bus(1'b1, CMD, 8'h01);
		bus(1'b1, CMD, 8'h01);
		rdchk("pending refused", STA, 32'h7);
		wait_idle();
		rdchk("held read", LAT, 32'ha4);
		bus(1'b1, STA, 8'h04);
		sel <= 4'h0;
		bus(1'b1, LAT, 8'h33);
		sel <= 4'h1;
		rdchk("sel ignored", LAT, 32'ha4);
		// a frozen clock enable must also freeze the programming timer
		bus(1'b1, CMD, 8'h03);
		ce_i <= 1'b0;
		repeat (30) @(posedge clk_i);
		chk("frozen stall", {31'h0, fstall}, 32'h1);
		ce_i <= 1'b1;
		wait_idle();
		rdchk("after freeze", STA, 32'h0);
		fetch(14'h0a2, 16'ha5a4);
		summarize();
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		summarize();
	end
endmodule : pfta_top_bench
